// ==== verilog/drsr_regs.svh ====
/*
 * Constants of the DMA request front end and channel-2 reload unit.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DRSR_REGS_SVH
`define DRSR_REGS_SVH

// ==========================================================
// Timing counts
// Three states from request detection to the DMA bus cycle
`define DRSR_REQ_STATES 3
`define DRSR_WAIT_LAST 2'h2

// ==========================================================
// Reload unit
`define DRSR_RELOAD_LAST 2'h3
`define DRSR_SIZE_BYTE 2'h0
`define DRSR_SIZE_WORD 2'h1
`define DRSR_SIZE_LONG 2'h2

// ==========================================================
// Reset values
`define DRSR_COUNT_RST 'h0
`define DRSR_ADDR_RST 32'h0

`endif

// ==== verilog/drsr_pkg.sv ====
/*
 * Types of the DMA request front end.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package drsr_pkg;

  // ==========================================================
  // Front end states
  typedef enum logic [1:0]
  {
    DRSR_IDLE = 2'b00,
    DRSR_WAIT = 2'b01,
    DRSR_DUMMY = 2'b10,
    DRSR_XFER = 2'b11
  } drsr_state_e;

  // ==========================================================
  // Channel mode configuration
  typedef struct packed
  {
    logic burst;
    logic single_addr;
    logic edge_det;
    logic int_enable;
  } drsr_cfg_s;

  // ==========================================================
  // Events that stop all transfers
  typedef struct packed
  {
    logic master_enable;
    logic nmi;
    logic address_error;
    logic standby;
  } drsr_stop_s;

endpackage : drsr_pkg

// ==== verilog/drsr_reload.sv ====
/*
 * Channel-2 source address reload and transfer count.
 * Assumes unit_done pulses once per completed unit transfer on SYS_CLK.
 */
`timescale 1ns/100ps
`include "drsr_regs.svh"

module drsr_reload #(
  parameter int CW = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reload_on,
  input wire logic [1:0] size,
  input wire logic src_load,
  input wire logic [31:0] src_value,
  input wire logic count_load,
  input wire logic [CW-1:0] count_value,
  input wire logic unit_done,
  input wire logic channel_enable,
  input wire drsr_pkg::drsr_stop_s stop,
  input wire logic end_flag_clear,
  output logic [31:0] source_address,
  output logic [CW-1:0] transfer_count,
  output logic end_flag
);

  logic [31:0] start_addr;
  logic [1:0] phase;
  logic [31:0] step;
  logic last_unit;
  logic clear_phase;

  // ==========================================================
  // Unit size step
  always_comb
  begin
    unique case (size)
      `DRSR_SIZE_WORD: step = 32'h2;
      `DRSR_SIZE_LONG: step = 32'h4;
      default: step = 32'h1; // R17
    endcase
  end

  assign last_unit = unit_done && (transfer_count == CW'(1));
  assign clear_phase = !stop.master_enable || !channel_enable || last_unit ||
    stop.nmi || stop.address_error || stop.standby; // R20

  // ==========================================================
  // Transfer count
  always_ff @(posedge clk)
  begin
    if (rst)
      transfer_count <= CW'(`DRSR_COUNT_RST);
    else if (count_load)
      transfer_count <= count_value;
    else if (unit_done && transfer_count != '0)
      transfer_count <= transfer_count - CW'(1); // R18
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      end_flag <= 1'b0;
    else if (last_unit)
      end_flag <= 1'b1; // R23
    else if (end_flag_clear)
      end_flag <= 1'b0;
  end

  // ==========================================================
  // Four-transfer phase and address
  always_ff @(posedge clk)
  begin
    if (rst)
      phase <= 2'h0; // R20
    else if (clear_phase)
      phase <= 2'h0; // R20
    else if (unit_done && reload_on)
      phase <= phase + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      start_addr <= `DRSR_ADDR_RST;
      source_address <= `DRSR_ADDR_RST;
    end
    else if (src_load)
    begin
      start_addr <= src_value;
      source_address <= src_value;
    end
    else if (unit_done && reload_on && phase == `DRSR_RELOAD_LAST)
      source_address <= start_addr; // R16
    else if (unit_done)
      source_address <= source_address + step;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  count_step_a : assert property ( // R18
    unit_done && !count_load && transfer_count != '0
    |=> transfer_count == $past(transfer_count) - CW'(1))
    else $error("Channel-2 count did not step down by one");

  addr_reload_a : assert property ( // R16
    unit_done && reload_on && !src_load && !clear_phase && phase == 2'h3
    |=> source_address == start_addr)
    else $error("Source address not restored after four transfers");

  reload_seen_c : cover property (unit_done && reload_on && phase == 2'h3);

endmodule : drsr_reload

// ==== verilog/drsr_top.sv ====
/*
 * External DMA request front end with channel-2 source address reload.
 * Assumes a bus state controller that pulses BUS_CYCLE_START_IN at the
 * start of every bus cycle and BUS_CYCLE_END_IN at the last state of the
 * DMA cycle that DMA_CYCLE_OUT asks for; it sets the cycle length.
 */
// Notes on behaviour
// (R01) Detect request by falling edge or low level
// (R02) DMA cycle at least three states after detection
// (R03) Single-address burst starts with one dummy cycle
// (R04) Dummy cycle: no acknowledge, no count
// (R05) Next sample opens one cycle before transfer
// (R06) No request at opening: sample every cycle
// (R07) Accepted strobe once per first sampling
// (R08) Edge burst: sample once, run to count end
// (R09) Cycle steal: same timing for all modes
// (R10) Acknowledge spans each single-address transfer cycle
// (R11) Level burst continues while requests sampled
// (R12) Dummy cycle ignored when opening second sample
// (R13) No new dummy unless transfers interrupted
// (R14) Requester gives new edge after halt
// (R15) Resume: strobe, dummy if single, then transfers
// (R16) Channel 2 reloads source every four transfers
// (R17) Reload works for byte, word, longword
// (R18) Count drops by one per unit transfer
// (R19) Software programs count as multiple of four
// (R20) Stop events clear reload phase, not registers
// (R21) Software reprograms channel 2 after such stop
// (R22) Bus cycle length set by bus controller
// (R23) Count end sets end flag and interrupt
// (R24) Request synchronised before detection
`timescale 1ns/100ps
`include "drsr_regs.svh"

module drsr_top #(
  parameter int CW = 16
) (
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic TRANSFER_REQUEST_N_IN,
  input wire drsr_pkg::drsr_cfg_s CFG_IN,
  input wire drsr_pkg::drsr_stop_s STOP_IN,
  input wire logic CHANNEL_ENABLE_IN,
  input wire logic COUNT_LOAD_IN,
  input wire logic [CW-1:0] COUNT_VALUE_IN,
  input wire logic END_FLAG_CLEAR_IN,
  input wire logic BUS_CYCLE_START_IN,
  input wire logic BUS_CYCLE_END_IN,
  input wire logic RELOAD_ON_IN,
  input wire logic [1:0] CH2_SIZE_IN,
  input wire logic CH2_SRC_LOAD_IN,
  input wire logic [31:0] CH2_SRC_VALUE_IN,
  input wire logic CH2_COUNT_LOAD_IN,
  input wire logic [CW-1:0] CH2_COUNT_VALUE_IN,
  input wire logic CH2_UNIT_DONE_IN,
  input wire logic CH2_CHANNEL_ENABLE_IN,
  input wire logic CH2_END_FLAG_CLEAR_IN,
  output logic DMA_CYCLE_OUT,
  output logic DUMMY_CYCLE_OUT,
  output logic TRANSFER_ACK_OUT,
  output logic REQUEST_ACCEPTED_STROBE_OUT,
  output logic [CW-1:0] TRANSFER_COUNT_OUT,
  output logic TRANSFER_END_FLAG_OUT,
  output logic END_IRQ_OUT,
  output logic [31:0] SOURCE_ADDRESS_CH2_OUT,
  output logic [CW-1:0] TRANSFER_COUNT_CH2_OUT,
  output logic CH2_END_FLAG_OUT
);

  drsr_pkg::drsr_state_e state;
  drsr_pkg::drsr_state_e next_state;
  logic req_s1;
  logic req_s2;
  logic req_s3;
  logic edge_seen;
  logic sample_open;
  logic pend;
  logic [1:0] wait_cnt;
  logic run_ok;
  logic hit;
  logic detect;
  logic go_wait;
  logic xfer_end;
  logic last_xfer;
  logic edge_burst;

  // ==========================================================
  // Request synchroniser and detection
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      req_s1 <= 1'b1;
      req_s2 <= 1'b1;
      req_s3 <= 1'b1;
    end
    else
    begin
      req_s1 <= TRANSFER_REQUEST_N_IN; // R24
      req_s2 <= req_s1; // R24
      req_s3 <= req_s2;
    end
  end

  assign edge_burst = CFG_IN.burst && CFG_IN.edge_det;
  assign run_ok = STOP_IN.master_enable && CHANNEL_ENABLE_IN && !STOP_IN.nmi &&
    !STOP_IN.address_error && !STOP_IN.standby && TRANSFER_COUNT_OUT != '0;
  assign hit = CFG_IN.edge_det ? edge_seen : !req_s2; // R01
  // Same path for every mode and address form
  assign detect = sample_open && hit && run_ok && !pend; // R09 R06
  assign go_wait = detect && state == drsr_pkg::DRSR_IDLE;
  assign xfer_end = state == drsr_pkg::DRSR_XFER && BUS_CYCLE_END_IN;
  assign last_xfer = xfer_end && TRANSFER_COUNT_OUT == CW'(1);

  // Falling edge held until sampled; only edges while sampling count
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      edge_seen <= 1'b0;
    else if (req_s3 && !req_s2 && sample_open)
      edge_seen <= 1'b1; // R01 R14
    else if (detect || !sample_open)
      edge_seen <= 1'b0;
  end

  // ==========================================================
  // Sample window
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      sample_open <= 1'b1;
    else if (next_state == drsr_pkg::DRSR_IDLE)
      sample_open <= 1'b1; // R06
    else if (detect)
      sample_open <= 1'b0;
    else if (BUS_CYCLE_START_IN && !edge_burst &&
      (state == drsr_pkg::DRSR_WAIT || state == drsr_pkg::DRSR_XFER))
      sample_open <= 1'b1; // R05 R11 R12
    // Bus cycle before the first transfer has begun by the last wait state
    else if (!edge_burst && state == drsr_pkg::DRSR_WAIT &&
      wait_cnt == `DRSR_WAIT_LAST)
      sample_open <= 1'b1; // R12
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      pend <= 1'b0;
    else if (next_state == drsr_pkg::DRSR_IDLE)
      pend <= 1'b0;
    // Start and continuation detects are consumed at once, not held
    else if (detect && !go_wait && !xfer_end)
      pend <= 1'b1; // R05 R06
    else if (xfer_end)
      pend <= 1'b0;
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      REQUEST_ACCEPTED_STROBE_OUT <= 1'b0;
    else
      REQUEST_ACCEPTED_STROBE_OUT <= detect; // R07 R08 R15
  end

  // ==========================================================
  // Cycle sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      drsr_pkg::DRSR_IDLE:
        if (go_wait)
          next_state = drsr_pkg::DRSR_WAIT;
      drsr_pkg::DRSR_WAIT:
        if (wait_cnt == `DRSR_WAIT_LAST)
          next_state = (CFG_IN.burst && CFG_IN.single_addr) ?
            drsr_pkg::DRSR_DUMMY : drsr_pkg::DRSR_XFER; // R02 R03 R15
      drsr_pkg::DRSR_DUMMY:
        if (BUS_CYCLE_END_IN)
          next_state = drsr_pkg::DRSR_XFER; // R22
      drsr_pkg::DRSR_XFER:
        if (xfer_end)
        begin
          if (last_xfer || !run_ok)
            next_state = drsr_pkg::DRSR_IDLE;
          else if (edge_burst)
            next_state = drsr_pkg::DRSR_XFER; // R08
          else if (CFG_IN.burst && (pend || detect))
            next_state = drsr_pkg::DRSR_XFER; // R11 R13
          else if (pend || detect)
            next_state = drsr_pkg::DRSR_WAIT;
          else
            next_state = drsr_pkg::DRSR_IDLE; // R13
        end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      state <= drsr_pkg::DRSR_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      wait_cnt <= 2'h0;
    else if (state != drsr_pkg::DRSR_WAIT)
      wait_cnt <= 2'h0;
    else
      wait_cnt <= wait_cnt + 2'h1; // R02
  end

  // ==========================================================
  // Bus cycle outputs
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      DMA_CYCLE_OUT <= 1'b0;
      DUMMY_CYCLE_OUT <= 1'b0;
      TRANSFER_ACK_OUT <= 1'b0;
    end
    else
    begin
      DMA_CYCLE_OUT <= next_state == drsr_pkg::DRSR_DUMMY ||
        next_state == drsr_pkg::DRSR_XFER;
      DUMMY_CYCLE_OUT <= next_state == drsr_pkg::DRSR_DUMMY; // R03
      TRANSFER_ACK_OUT <= next_state == drsr_pkg::DRSR_XFER &&
        CFG_IN.single_addr; // R10 R04
    end
  end

  // ==========================================================
  // Transfer count and end flag
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      TRANSFER_COUNT_OUT <= CW'(`DRSR_COUNT_RST);
    else if (COUNT_LOAD_IN && state == drsr_pkg::DRSR_IDLE)
      TRANSFER_COUNT_OUT <= COUNT_VALUE_IN;
    else if (xfer_end)
      TRANSFER_COUNT_OUT <= TRANSFER_COUNT_OUT - CW'(1); // R04 R18
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      TRANSFER_END_FLAG_OUT <= 1'b0;
    else if (last_xfer)
      TRANSFER_END_FLAG_OUT <= 1'b1; // R23
    else if (END_FLAG_CLEAR_IN)
      TRANSFER_END_FLAG_OUT <= 1'b0;
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      END_IRQ_OUT <= 1'b0;
    else
      END_IRQ_OUT <= CFG_IN.int_enable && (TRANSFER_END_FLAG_OUT || last_xfer); // R23
  end

  // ==========================================================
  // Channel-2 reload
  drsr_reload #(
    .CW(CW)
  ) u_reload (
    .clk(SYS_CLK_IN),
    .rst(SYS_RST_IN),
    .reload_on(RELOAD_ON_IN),
    .size(CH2_SIZE_IN),
    .src_load(CH2_SRC_LOAD_IN),
    .src_value(CH2_SRC_VALUE_IN),
    .count_load(CH2_COUNT_LOAD_IN),
    .count_value(CH2_COUNT_VALUE_IN),
    .unit_done(CH2_UNIT_DONE_IN),
    .channel_enable(CH2_CHANNEL_ENABLE_IN),
    .stop(STOP_IN),
    .end_flag_clear(CH2_END_FLAG_CLEAR_IN),
    .source_address(SOURCE_ADDRESS_CH2_OUT),
    .transfer_count(TRANSFER_COUNT_CH2_OUT),
    .end_flag(CH2_END_FLAG_OUT)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  req_delay_a : assert property ( // R02
    go_wait |=> !DMA_CYCLE_OUT [*3] ##1 DMA_CYCLE_OUT)
    else $error("DMA cycle not three states after detection");

  dummy_first_a : assert property ( // R03
    state == drsr_pkg::DRSR_WAIT && wait_cnt == 2'h2 && CFG_IN.burst &&
    CFG_IN.single_addr |=> DUMMY_CYCLE_OUT && !TRANSFER_ACK_OUT)
    else $error("Single-address burst did not open with a dummy cycle");

  dummy_quiet_a : assert property ( // R04
    state == drsr_pkg::DRSR_DUMMY && !COUNT_LOAD_IN
    |=> !TRANSFER_ACK_OUT || $past(BUS_CYCLE_END_IN) ##0
    TRANSFER_COUNT_OUT == $past(TRANSFER_COUNT_OUT))
    else $error("Dummy cycle acknowledged or counted");

  strobe_pulse_a : assert property ( // R07
    REQUEST_ACCEPTED_STROBE_OUT |=> !REQUEST_ACCEPTED_STROBE_OUT)
    else $error("Accepted strobe longer than one cycle");

  edge_once_a : assert property ( // R08
    edge_burst && state != drsr_pkg::DRSR_IDLE |-> !detect)
    else $error("Edge burst resampled the request");

  ack_span_a : assert property ( // R10
    TRANSFER_ACK_OUT |-> state == drsr_pkg::DRSR_XFER && DMA_CYCLE_OUT)
    else $error("Acknowledge outside a transfer cycle");

  no_redummy_a : assert property ( // R13
    xfer_end && run_ok && !last_xfer && CFG_IN.burst && pend
    |=> state == drsr_pkg::DRSR_XFER && !DUMMY_CYCLE_OUT)
    else $error("Dummy cycle inserted in continued burst");

  dummy_skip_a : assert property ( // R12
    state == drsr_pkg::DRSR_DUMMY && !sample_open |=> !sample_open)
    else $error("Sample window opened at the dummy cycle");

  end_flag_a : assert property ( // R23
    last_xfer |=> TRANSFER_END_FLAG_OUT ##1 (END_IRQ_OUT || !$past(CFG_IN.int_enable)))
    else $error("End flag not set at count end");

  dummy_seen_c : cover property (DUMMY_CYCLE_OUT ##[1:40] TRANSFER_ACK_OUT);
  burst_run_c : cover property (xfer_end && next_state == drsr_pkg::DRSR_XFER);
  steal_again_c : cover property (xfer_end && next_state == drsr_pkg::DRSR_WAIT);

endmodule : drsr_top

// ==== testbench/drsr_requester.sv ====
/*
 * Model of the external device that raises DMA transfer requests.
 * Assumes the bench clock and its synchronous active-high reset.
 */
`timescale 1ns/100ps

module drsr_requester (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic edge_in,
  input wire logic strobe_in,
  output logic req_n_out
);
  // ==========================================================
  // Request pin, pulled up while idle
  always_ff @(posedge clk_in)
  begin
    if (rst_in || !go_in)
      req_n_out <= 1'b1;
    else if (edge_in && strobe_in)
      req_n_out <= 1'b1;
    else
      req_n_out <= 1'b0;
  end
endmodule : drsr_requester

// ==== testbench/drsr_top_tb.sv ====
/*
 * Self-checking bench of the DMA request front end and channel-2 reload.
 * Assumes the requester model and a bus controller emulated here.
 */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end

module drsr_top_tb;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, req_n, cen = 1'b0, cload = 1'b0;
  logic eclr = 1'b0, bstart = 1'b0, bend = 1'b0, ron = 1'b0, c2load = 1'b0;
  logic c2cload = 1'b0, c2done = 1'b0, c2en = 1'b0, c2eclr = 1'b0;
  logic [1:0] c2size = 2'h0;
  logic [31:0] c2src = 32'h0, seed = 32'h76a8, src2;
  logic [15:0] cval = 16'h0, c2val = 16'h0, cnt, cnt2, cnt_d;
  logic dma, dummy, ack, strobe, tef, irq, ef2, dum_d = 1'b0;
  drsr_pkg::drsr_cfg_s cfg = '0;
  drsr_pkg::drsr_stop_s stop = 4'h8;
  int fails = 0, checked = 0, nstb = 0, nack = 0, ndum = 0, ph = 0, len = 3;

  drsr_top #(.CW(16)) u_dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst),
    .TRANSFER_REQUEST_N_IN(req_n), .CFG_IN(cfg), .STOP_IN(stop),
    .CHANNEL_ENABLE_IN(cen), .COUNT_LOAD_IN(cload), .COUNT_VALUE_IN(cval),
    .END_FLAG_CLEAR_IN(eclr), .BUS_CYCLE_START_IN(bstart), .BUS_CYCLE_END_IN(bend),
    .RELOAD_ON_IN(ron), .CH2_SIZE_IN(c2size), .CH2_SRC_LOAD_IN(c2load),
    .CH2_SRC_VALUE_IN(c2src), .CH2_COUNT_LOAD_IN(c2cload), .CH2_COUNT_VALUE_IN(c2val),
    .CH2_UNIT_DONE_IN(c2done), .CH2_CHANNEL_ENABLE_IN(c2en),
    .CH2_END_FLAG_CLEAR_IN(c2eclr), .DMA_CYCLE_OUT(dma), .DUMMY_CYCLE_OUT(dummy),
    .TRANSFER_ACK_OUT(ack), .REQUEST_ACCEPTED_STROBE_OUT(strobe),
    .TRANSFER_COUNT_OUT(cnt), .TRANSFER_END_FLAG_OUT(tef), .END_IRQ_OUT(irq),
    .SOURCE_ADDRESS_CH2_OUT(src2), .TRANSFER_COUNT_CH2_OUT(cnt2),
    .CH2_END_FLAG_OUT(ef2));

  drsr_requester u_req (.clk_in(clk), .rst_in(rst), .go_in(go), .edge_in(cfg.edge_det),
    .strobe_in(strobe), .req_n_out(req_n));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  always #4 clk = ~clk;

  // ==========================================================
  // Bus cycles of random length, end pulse only in DMA cycles
  always @(posedge clk)
  begin
    ph = (ph + 1 >= len) ? 0 : ph + 1;
    if (ph == 0)
      len = 2 + rnd() % 3;
    bstart <= (ph == 0);
    bend <= dma && (ph == len - 1);
  end

  // ==========================================================
  // Event counts and per-cycle checks
  always @(posedge clk)
  begin
    if (!rst)
    begin
      nstb += strobe;
      // One real transfer per bus cycle end seen while acknowledged
      if (ack && bend)
        nack++;
      if (dummy && !dum_d)
        ndum++;
      if (dummy)
        `CHK("ack_in_dummy", 1'b0, ack)
      if (dummy && dum_d)
        `CHK("cnt_in_dummy", cnt_d, cnt)
    end
    dum_d = dummy;
    cnt_d = cnt;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wait_tef();
    int i;
    for (i = 0; i < 4000 && tef !== 1'b1; i++)
      @(posedge clk);
    `CHK("end_flag", 1'b1, tef)
  endtask : wait_tef

  task automatic start(input logic [3:0] c, input logic [15:0] n);
    @(posedge clk);
    cfg <= c;
    cval <= n;
    cload <= 1'b1;
    eclr <= 1'b1;
    @(posedge clk);
    cload <= 1'b0;
    eclr <= 1'b0;
    nstb = 0;
    nack = 0;
    ndum = 0;
    go <= 1'b1;
  endtask : start

  task automatic job(input logic [2:0] m, input int n);
    int i;
    start({m, seed[3]}, 16'(n));
    for (i = 0; i < 200 && strobe !== 1'b1; i++)
      @(posedge clk);
    tick(2);
    `CHK("dma_early", 1'b0, dma)
    tick(1);
    `CHK("dma_start", 1'b1, dma)
    wait_tef();
    go <= 1'b0;
    tick(2);
    `CHK("count_end", 16'h0, cnt)
    `CHK("irq", cfg.int_enable, irq)
    `CHK("acks", m[1] ? n : 0, nack)
    `CHK("dummies", (m[2] & m[1]) ? 1 : 0, ndum)
    if (m[2] & m[0])
      `CHK("strobes_edge", 1, nstb)
    else
      `CHK("strobes", 1'b1, nstb >= n)
    $display("test mode %0d count %0d done", m, n);
  endtask : job

  task automatic done2();
    c2done <= 1'b1;
    @(posedge clk);
    c2done <= 1'b0;
    tick(2);
  endtask : done2

  task automatic load2(input logic [31:0] a, input logic [1:0] sz);
    @(posedge clk);
    c2size <= sz;
    c2src <= a;
    c2load <= 1'b1;
    c2val <= 16'h8;
    c2cload <= 1'b1;
    c2eclr <= 1'b1;
    @(posedge clk);
    c2load <= 1'b0;
    c2cload <= 1'b0;
    c2eclr <= 1'b0;
  endtask : load2

  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    results();
  end

  initial
  begin
    int m, k, i;
    logic [31:0] a;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tick(3);
    `CHK("count_rst", 16'h0, cnt)
    `CHK("src2_rst", 32'h0, src2)
    `CHK("dma_rst", 1'b0, dma)
    cen <= 1'b1;
    c2en <= 1'b1;
    ron <= 1'b1;
    for (m = 0; m < 8; m++)
      job(m[2:0], 1 + rnd() % 6);
    // Edge burst halted by an interrupt, then resumed by a new edge
    start(4'he, 16'h8);
    for (i = 0; i < 2000 && nack < 3; i++)
      @(posedge clk);
    stop.nmi <= 1'b1;
    for (i = 0; i < 200 && dma !== 1'b0; i++)
      @(posedge clk);
    tick(6);
    `CHK("halt_idle", 1'b0, dma)
    stop.nmi <= 1'b0;
    go <= 1'b0;
    tick(3);
    go <= 1'b1;
    wait_tef();
    go <= 1'b0;
    `CHK("resume_strobes", 2, nstb)
    `CHK("resume_dummies", 2, ndum)
    `CHK("resume_acks", 8, nack)
    $display("test halt and resume done");
    for (m = 0; m < 3; m++)
    begin
      a = rnd() & 32'hffff_fff0;
      load2(a, m[1:0]);
      for (k = 1; k <= 8; k++)
      begin
        done2();
        `CHK("src2", a + (k % 4) * (1 << m), src2)
        `CHK("cnt2", 16'(8 - k), cnt2)
      end
      `CHK("ch2_end", 1'b1, ef2)
      load2(a, m[1:0]);
      done2();
      done2();
      stop.nmi <= 1'b1;
      tick(2);
      stop.nmi <= 1'b0;
      for (k = 0; k < 4; k++)
        done2();
      `CHK("src2_phase_clr", a, src2)
      `CHK("cnt2_kept", 16'h2, cnt2)
      $display("test reload size %0d done", m);
    end
    results();
  end
endmodule : drsr_top_tb
